// ==== include/pcs_map.svh ====
// Register offsets, reset values and fixed constants of the set-point law
`ifndef PCS_MAP_SVH
`define PCS_MAP_SVH

// Byte offsets on the APB register bus
`define PCS_OFF_CTRL      8'h00
`define PCS_OFF_SP_MAX    8'h04
`define PCS_OFF_SP_BENTRY 8'h08
`define PCS_OFF_SP_BEXIT  8'h0C
`define PCS_OFF_SP_START  8'h10
`define PCS_OFF_FB_RANGE  8'h14
`define PCS_OFF_FB_MIN    8'h18
`define PCS_OFF_CS_RANGE  8'h1C
`define PCS_OFF_NEG_BASE  8'h20
`define PCS_OFF_NEG_SLOPE 8'h24
`define PCS_OFF_TRANS_NOM 8'h28
`define PCS_OFF_VCR_NOM   8'h2C
`define PCS_OFF_MAG_PP    8'h30
`define PCS_OFF_PROP_DLY  8'h34
`define PCS_OFF_STAT      8'h38
`define PCS_OFF_RESULT    8'h3C

// Highest writable configuration index (offset / 4)
`define PCS_CFG_LAST      4'hD

// Control register fields
`define PCS_CTRL_EN_BIT    0
`define PCS_CTRL_VALLEY_BIT 1

// Reset values
`define PCS_RST_CTRL      16'h0000
`define PCS_RST_SP_MAX    16'h0200
`define PCS_RST_SP_BENTRY 16'h0020
`define PCS_RST_SP_BEXIT  16'h0040
`define PCS_RST_SP_START  16'h0280
`define PCS_RST_FB_RANGE  16'h0800
`define PCS_RST_FB_MIN    16'h0100
`define PCS_RST_CS_RANGE  16'h0400
`define PCS_RST_NEG_BASE  16'h0020
`define PCS_RST_NEG_SLOPE 16'h0010
`define PCS_RST_TRANS_NOM 16'h0040
`define PCS_RST_VCR_NOM   16'h0100
`define PCS_RST_MAG_PP    16'h0080
`define PCS_RST_PROP_DLY  16'h0004

// Nominal set-point fraction, 50 % as Q0.8
`define PCS_NOM_FRACTION  8'h80

`endif

// ==== include/pcs_pkg.sv ====
// Types shared by the set-point law design
package pcs_pkg;

    typedef enum logic [5:0]
    {
        ST_IDLE  = 6'b00_0001,
        ST_SP    = 6'b00_0010,
        ST_LM    = 6'b00_0100,
        ST_OVS   = 6'b00_1000,
        ST_RATIO = 6'b01_0000,
        ST_FIN   = 6'b10_0000
    } pcs_state_e;

    typedef logic [15:0] pcs_word_t;

endpackage

// ==== design/pcs_seqdiv.sv ====
// Sequential restoring divider, one quotient bit per clock
`timescale 1ns/1ps
`default_nettype none

module pcs_seqdiv #(
    parameter int WIDTH = 32
) (
    // Clock and reset
    input  wire logic             mclk_in,
    input  wire logic             rst_n_in,
    // Request
    input  wire logic             start_in,
    input  wire logic [WIDTH-1:0] num_in,
    input  wire logic [WIDTH-1:0] den_in,
    // Answer
    output logic                  busy_out,
    output logic                  done_out,
    output logic [WIDTH-1:0]      quo_out
);

    localparam int CW = $clog2(WIDTH + 1);

    logic [WIDTH-1:0] rem_q, rem_d, quo_q, quo_d, den_q, den_d;
    logic [CW-1:0]    cnt_q, cnt_d;
    logic             busy_q, busy_d, done_q, done_d;
    logic [WIDTH:0]   trial;

    always_comb
    begin
        rem_d  = rem_q;
        quo_d  = quo_q;
        den_d  = den_q;
        cnt_d  = cnt_q;
        busy_d = busy_q;
        done_d = 1'b0;
        trial  = {rem_q, quo_q[WIDTH-1]} - {1'b0, den_q};
        if (start_in && !busy_q)
        begin
            rem_d  = '0;
            quo_d  = num_in;
            den_d  = den_in;
            cnt_d  = CW'(WIDTH);
            busy_d = 1'b1;
        end
        else if (busy_q)
        begin
            // Zero divisor gives all ones, a safe saturated answer
            if (trial[WIDTH])
            begin
                rem_d = {rem_q[WIDTH-2:0], quo_q[WIDTH-1]};
                quo_d = {quo_q[WIDTH-2:0], 1'b0};
            end
            else
            begin
                rem_d = trial[WIDTH-1:0];
                quo_d = {quo_q[WIDTH-2:0], 1'b1};
            end
            cnt_d = cnt_q - CW'(1);
            if (cnt_q == CW'(1))
            begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            rem_q  <= '0;
            quo_q  <= '0;
            den_q  <= '0;
            cnt_q  <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end
        else
        begin
            rem_q  <= rem_d;
            quo_q  <= quo_d;
            den_q  <= den_d;
            cnt_q  <= cnt_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    assign busy_out = busy_q;
    assign done_out = done_q;
    assign quo_out  = quo_q;

endmodule

`default_nettype wire

// ==== design/pcs_peak_cmp.sv ====
// Peak comparator ending high-side conduction at the threshold
`timescale 1ns/1ps
`default_nettype none

module pcs_peak_cmp #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input  wire logic             mclk_in,
    input  wire logic             rst_n_in,
    // Sense and threshold
    input  wire logic             hs_on_in,
    input  wire logic [WIDTH-1:0] sense_in,
    input  wire logic [WIDTH-1:0] thr_in,
    // Turn-off request
    output logic                  hs_end_out
);

    logic end_q, end_d, fired_q, fired_d;

    always_comb
    begin
        end_d   = 1'b0;
        fired_d = fired_q;
        if (!hs_on_in)
        begin
            fired_d = 1'b0;
        end
        // One pulse per conduction phase
        else if (!fired_q && (sense_in >= thr_in))
        begin
            end_d   = 1'b1;
            fired_d = 1'b1;
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            end_q   <= 1'b0;
            fired_q <= 1'b0;
        end
        else
        begin
            end_q   <= end_d;
            fired_q <= fired_d;
        end
    end

    assign hs_end_out = end_q;

endmodule

`default_nettype wire

// ==== design/pcs_setpoint_law.sv ====
// Peak-current set-point law with delay compensation and APB registers
//
// Notes on behaviour
// - Feedback maps linearly to set-point between burst-entry and maximum levels.
// - Nominal set-point fraction is fixed at 50 percent, unitless.
// - Set-points are percentages of nominal; feedback level scales with range plus offset.
// - Burst-exit set-point applies only while burst is active, no feedback level.
// - Start-up set-point applies only during output start-up control.
// - High-side conduction ends when sensed shunt voltage reaches the threshold.
// - Threshold is set-point term plus negative magnetization; valley mode scales by period ratio.
// - Negative magnetization target depends on input voltage only.
// - Positive target equals set-point minus negative magnetization.
// - Low-side on-time never shortens below the nominal transfer period.
// - Valley mode inserts a waiting gap after the nominal transfer period.
// - Extended period comes from valley-skipping control, given as input.
// - Overshoot is input minus reflected voltage, over inductance, times delay.
// - Input voltage from its sense pin, reflected voltage from zero-cross pin.
// - Inductance is nominal capacitor voltage times transfer period over peak-to-peak.
// - Compensated peak target is positive target minus overshoot, used for threshold; the code instead subtracts overshoot from the threshold sum.
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_map.svh"

module pcs_setpoint_law (
    // Clock and reset
    input  wire logic        mclk_in,
    input  wire logic        rst_n_in,
    // APB slave
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    // Digitised pin readings
    input  wire logic [15:0] feedback_pin_in,
    input  wire logic [15:0] input_voltage_sense_pin_in,
    input  wire logic [15:0] zero_cross_pin_in,
    input  wire logic [15:0] sense_code_in,
    // Cycle and operating state
    input  wire logic        cycle_start_in,
    input  wire logic        hs_on_in,
    input  wire logic        burst_active_in,
    input  wire logic        startup_active_in,
    input  wire logic [15:0] base_half_bridge_period_in,
    input  wire logic [15:0] extended_half_bridge_period_in,
    input  wire logic [15:0] ls_on_request_in,
    // Results
    output logic      [15:0] threshold_out,
    output logic      [15:0] setpoint_out,
    output logic      [15:0] positive_magnetization_target_out,
    output logic      [15:0] negative_magnetization_target_out,
    output logic      [15:0] delay_compensation_out,
    output logic      [15:0] ls_on_time_out,
    output logic      [15:0] wait_gap_out,
    output logic             update_done_out,
    output logic             hs_end_out
);

    localparam logic [15:0] CFG_RST [0:13] = '{
        `PCS_RST_CTRL, `PCS_RST_SP_MAX, `PCS_RST_SP_BENTRY, `PCS_RST_SP_BEXIT,
        `PCS_RST_SP_START, `PCS_RST_FB_RANGE, `PCS_RST_FB_MIN, `PCS_RST_CS_RANGE,
        `PCS_RST_NEG_BASE, `PCS_RST_NEG_SLOPE, `PCS_RST_TRANS_NOM, `PCS_RST_VCR_NOM,
        `PCS_RST_MAG_PP, `PCS_RST_PROP_DLY};

    // Register file and bus state
    logic [15:0] cfg_q [0:13];
    logic [15:0] cfg_d [0:13];
    logic [31:0] prdata_q, prdata_d;
    logic        pready_q, pready_d, pslverr_q, pslverr_d;
    logic [3:0]  idx;

    // Calculation state
    pcs_pkg::pcs_state_e st_q, st_d;
    logic        issued_q, issued_d;
    logic [15:0] fb_q, fb_d, vin_q, vin_d, vcr_q, vcr_d, pb_q, pb_d, pe_q, pe_d;
    logic        valley_q, valley_d;
    logic [15:0] sp_q, sp_d, neg_q, neg_d, sum_q, sum_d, pos_q, pos_d;
    logic [31:0] lm_q, lm_d;
    logic [15:0] ovs_q, ovs_d, scaled_q, scaled_d, thr_q, thr_d;
    logic [15:0] comp_q, comp_d, gap_q, gap_d, lson_q, lson_d;
    logic        done_q, done_d;

    // Divider hookup
    logic        div_start, div_busy, div_done;
    logic [31:0] div_num, div_den, div_quo;

    // Aliases into the configuration array
    logic [15:0] sp_max, sp_bentry, sp_bexit, sp_start, fb_range, fb_min, cs_range;
    logic [15:0] neg_base, neg_slope, trans_nom, vcr_nom, mag_pp, prop_dly;
    logic [23:0] fb_den_w, sp_fb_w, neg_w;
    logic [39:0] base_w;
    logic [16:0] sum_w;
    logic [15:0] fb_excess, dv, quo16;
    logic [31:0] sp_quo;

    assign sp_max    = cfg_q[1];
    assign sp_bentry = cfg_q[2];
    assign sp_bexit  = cfg_q[3];
    assign sp_start  = cfg_q[4];
    assign fb_range  = cfg_q[5];
    assign fb_min    = cfg_q[6];
    assign cs_range  = cfg_q[7];
    assign neg_base  = cfg_q[8];
    assign neg_slope = cfg_q[9];
    assign trans_nom = cfg_q[10];
    assign vcr_nom   = cfg_q[11];
    assign mag_pp    = cfg_q[12];
    assign prop_dly  = cfg_q[13];
    assign idx       = paddr_in[5:2];

    // APB decode: registered answer, zero wait states
    always_comb
    begin
        cfg_d     = cfg_q;
        prdata_d  = prdata_q;
        pready_d  = 1'b0;
        pslverr_d = 1'b0;
        if (psel_in && !penable_in)
        begin
            pready_d = 1'b1;
            prdata_d = 32'h0000_0000;
            if (paddr_in[7:6] != 2'b00 || paddr_in[1:0] != 2'b00)
                pslverr_d = 1'b1;
            else if (paddr_in == `PCS_OFF_STAT)
                prdata_d = {15'h0000, st_q != pcs_pkg::ST_IDLE, thr_q};
            else if (paddr_in == `PCS_OFF_RESULT)
                prdata_d = {ovs_q, sp_q};
            else
                prdata_d = {16'h0000, cfg_q[idx]};
        end
        if (psel_in && penable_in && pready_q && pwrite_in && !pslverr_q
            && idx <= `PCS_CFG_LAST && paddr_in[7:6] == 2'b00)
        begin
            cfg_d[idx] = pwdata_in[15:0];
        end
    end

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            cfg_q     <= CFG_RST;
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            cfg_q     <= cfg_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // fixed fraction
    // Nominal feedback span is range times the 50 percent fraction
    assign fb_den_w  = fb_range * `PCS_NOM_FRACTION;
    assign fb_excess = (fb_q > fb_min) ? fb_q - fb_min : 16'h0000;
    assign sp_quo    = div_quo;
    assign sp_fb_w   = (sp_quo[31:16] != 16'h0000) ? 24'hFF_FFFF : {8'h00, sp_quo[15:0]};
    assign base_w    = sp_q * `PCS_NOM_FRACTION * cs_range;
    assign neg_w     = {8'h00, neg_base} + 24'((32'(vin_q) * 32'(neg_slope)) >> 8);
    assign sum_w     = {1'b0, base_w[31:16]} + {1'b0, neg_q};
    assign dv        = (vin_q > vcr_q) ? vin_q - vcr_q : 16'h0000;
    assign quo16     = (div_quo[31:16] != 16'h0000) ? 16'hFFFF : div_quo[15:0];
    assign div_start = (st_q != pcs_pkg::ST_IDLE) && (st_q != pcs_pkg::ST_FIN)
                       && !issued_q && !div_busy;

    // Divider operands per step
    always_comb
    begin
        div_num = 32'h0000_0000;
        div_den = 32'h0000_0000;
        case (st_q)
            pcs_pkg::ST_SP:
            begin
                div_num = {8'h00, fb_excess, 8'h00};
                div_den = {16'h0000, fb_den_w[23:8]};
            end
            pcs_pkg::ST_LM:
            begin
                div_num = vcr_nom * trans_nom;
                div_den = {16'h0000, mag_pp};
            end
            pcs_pkg::ST_OVS:
            begin
                div_num = dv * prop_dly;
                div_den = lm_q;
            end
            pcs_pkg::ST_RATIO:
            begin
                div_num = sum_q * pe_q;
                div_den = {16'h0000, pb_q};
            end
            default:
            begin
                div_num = 32'h0000_0000;
                div_den = 32'h0000_0000;
            end
        endcase
    end

    pcs_seqdiv #(
        .WIDTH (32)
    ) u_div (
        .mclk_in  (mclk_in),
        .rst_n_in (rst_n_in),
        .start_in (div_start),
        .num_in   (div_num),
        .den_in   (div_den),
        .busy_out (div_busy),
        .done_out (div_done),
        .quo_out  (div_quo)
    );

    // Per-cycle calculation sequence
    always_comb
    begin
        st_d     = st_q;
        issued_d = issued_q | div_start;
        fb_d     = fb_q;
        vin_d    = vin_q;
        vcr_d    = vcr_q;
        pb_d     = pb_q;
        pe_d     = pe_q;
        valley_d = valley_q;
        sp_d     = sp_q;
        neg_d    = neg_q;
        sum_d    = sum_q;
        pos_d    = pos_q;
        lm_d     = lm_q;
        ovs_d    = ovs_q;
        scaled_d = scaled_q;
        thr_d    = thr_q;
        comp_d   = comp_q;
        gap_d    = gap_q;
        lson_d   = lson_q;
        done_d   = 1'b0;
        case (st_q)
            pcs_pkg::ST_IDLE:
            begin
                if (cycle_start_in && cfg_q[0][`PCS_CTRL_EN_BIT])
                begin
                    fb_d     = feedback_pin_in;
                    vin_d    = input_voltage_sense_pin_in;
                    vcr_d    = zero_cross_pin_in;
                    pb_d     = base_half_bridge_period_in;
                    pe_d     = extended_half_bridge_period_in;
                    valley_d = cfg_q[0][`PCS_CTRL_VALLEY_BIT];
                    issued_d = 1'b0;
                    st_d     = pcs_pkg::ST_SP;
                end
            end
            pcs_pkg::ST_SP:
            begin
                if (div_done)
                begin
                    if (startup_active_in)
                        sp_d = sp_start;
                    else if (burst_active_in)
                        sp_d = sp_bexit;
                    else if (sp_fb_w > {8'h00, sp_max})
                        sp_d = sp_max;
                    else if (sp_fb_w < {8'h00, sp_bentry})
                        sp_d = sp_bentry;
                    else
                        sp_d = sp_fb_w[15:0];
                    neg_d    = (neg_w[23:16] != 8'h00) ? 16'hFFFF : neg_w[15:0];
                    issued_d = 1'b0;
                    st_d     = pcs_pkg::ST_LM;
                end
            end
            pcs_pkg::ST_LM:
            begin
                sum_d = sum_w[16] ? 16'hFFFF : sum_w[15:0];
                pos_d = (base_w[31:16] > neg_q) ? base_w[31:16] - neg_q : 16'h0000;
                if (div_done)
                begin
                    lm_d     = div_quo;
                    issued_d = 1'b0;
                    st_d     = pcs_pkg::ST_OVS;
                end
            end
            pcs_pkg::ST_OVS:
            begin
                if (div_done)
                begin
                    ovs_d    = quo16;
                    scaled_d = sum_q;
                    issued_d = 1'b0;
                    st_d     = valley_q ? pcs_pkg::ST_RATIO : pcs_pkg::ST_FIN;
                end
            end
            pcs_pkg::ST_RATIO:
            begin
                if (div_done)
                begin
                    scaled_d = quo16;
                    issued_d = 1'b0;
                    st_d     = pcs_pkg::ST_FIN;
                end
            end
            pcs_pkg::ST_FIN:
            begin
                comp_d = (pos_q > ovs_q) ? pos_q - ovs_q : 16'h0000;
                if (scaled_q <= ovs_q)
                    thr_d = 16'h0000;
                else if (scaled_q - ovs_q > cs_range)
                    thr_d = cs_range;
                else
                    thr_d = scaled_q - ovs_q;
                gap_d = (valley_q && pe_q > pb_q) ? pe_q - pb_q : 16'h0000;
                lson_d   = (ls_on_request_in > trans_nom) ? ls_on_request_in : trans_nom;
                done_d   = 1'b1;
                issued_d = 1'b0;
                st_d     = pcs_pkg::ST_IDLE;
            end
            default:
            begin
                issued_d = 1'b0;
                st_d     = pcs_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_in)
    begin
        if (!rst_n_in)
        begin
            st_q     <= pcs_pkg::ST_IDLE;
            issued_q <= 1'b0;
            fb_q     <= 16'h0000;
            vin_q    <= 16'h0000;
            vcr_q    <= 16'h0000;
            pb_q     <= 16'h0000;
            pe_q     <= 16'h0000;
            valley_q <= 1'b0;
            sp_q     <= 16'h0000;
            neg_q    <= 16'h0000;
            sum_q    <= 16'h0000;
            pos_q    <= 16'h0000;
            lm_q     <= 32'h0000_0000;
            ovs_q    <= 16'h0000;
            scaled_q <= 16'h0000;
            thr_q    <= 16'h0000;
            comp_q   <= 16'h0000;
            gap_q    <= 16'h0000;
            lson_q   <= 16'h0000;
            done_q   <= 1'b0;
        end
        else
        begin
            st_q     <= st_d;
            issued_q <= issued_d;
            fb_q     <= fb_d;
            vin_q    <= vin_d;
            vcr_q    <= vcr_d;
            pb_q     <= pb_d;
            pe_q     <= pe_d;
            valley_q <= valley_d;
            sp_q     <= sp_d;
            neg_q    <= neg_d;
            sum_q    <= sum_d;
            pos_q    <= pos_d;
            lm_q     <= lm_d;
            ovs_q    <= ovs_d;
            scaled_q <= scaled_d;
            thr_q    <= thr_d;
            comp_q   <= comp_d;
            gap_q    <= gap_d;
            lson_q   <= lson_d;
            done_q   <= done_d;
        end
    end

    pcs_peak_cmp #(
        .WIDTH (16)
    ) u_cmp (
        .mclk_in    (mclk_in),
        .rst_n_in   (rst_n_in),
        .hs_on_in   (hs_on_in),
        .sense_in   (sense_code_in),
        .thr_in     (thr_q),
        .hs_end_out (hs_end_out)
    );

    assign prdata_out                        = prdata_q;
    assign pready_out                        = pready_q;
    assign pslverr_out                       = pslverr_q;
    assign threshold_out                     = thr_q;
    assign setpoint_out                      = sp_q;
    assign positive_magnetization_target_out = comp_q;
    assign negative_magnetization_target_out = neg_q;
    assign delay_compensation_out            = ovs_q;
    assign ls_on_time_out                    = lson_q;
    assign wait_gap_out                      = gap_q;
    assign update_done_out                   = done_q;

endmodule

`default_nettype wire

// ==== sim/pcs_law_asserts.sv ====
// Port-level checks for the set-point law
`timescale 1ns/1ps
`default_nettype none

module pcs_law_asserts (
    input wire logic        mclk_in,
    input wire logic        rst_n_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic [7:0]  paddr_in,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    input wire logic        hs_on_in,
    input wire logic [15:0] sense_code_in,
    input wire logic [15:0] threshold_out,
    input wire logic [15:0] wait_gap_out,
    input wire logic        update_done_out,
    input wire logic        hs_end_out
);
    default clocking @(posedge mclk_in);
    endclocking
    default disable iff (!rst_n_in);

    setup_answer_a: assert property (psel_in && !penable_in |=> pready_out)
        else $error("no ready after setup");
    ready_access_a: assert property (pready_out |-> psel_in && penable_in)
        else $error("ready outside access");
    addr_error_a: assert property (pready_out |->
        pslverr_out == (paddr_in >= 8'h40 || paddr_in[1:0] != 2'b00))
        else $error("error flag wrong");
    end_cause_a: assert property ( // stop cause
        hs_end_out |-> $past(hs_on_in && sense_code_in >= threshold_out))
        else $error("stop without peak");
    end_single_a: assert property (hs_end_out |=> !hs_end_out) // one pulse
        else $error("stop pulse too long");
    done_single_a: assert property (update_done_out |=> !update_done_out) // one pulse
        else $error("done pulse too long");
    thr_update_a: assert property ( // update marked
        $changed(threshold_out) |-> ##[0:1] update_done_out)
        else $error("threshold moved silently");
    gap_update_a: assert property ( // update marked
        $changed(wait_gap_out) |-> ##[0:1] update_done_out)
        else $error("gap moved silently");
endmodule

`default_nettype wire

// ==== sim/pcs_stage_model.sv ====
// Power stage stand-in: shunt ramp while the high side conducts
`timescale 1ns/1ps
`default_nettype none

module pcs_stage_model #(
    parameter logic [15:0] SLOPE = 16'h0040
) (
    input  wire logic        mclk_in,
    input  wire logic        rst_n_in,
    input  wire logic        go_in,
    input  wire logic        hs_end_in,
    output logic             hs_on_out,
    output logic [15:0]      sense_out,
    output logic [15:0]      peak_out
);
    // Ramp keeps rising until the stop lands, as a real delay would
    always_ff @(posedge mclk_in)
    begin
        peak_out <= !rst_n_in ? 16'h0000 : hs_end_in ? sense_out : peak_out;
        if (!rst_n_in || hs_end_in)
        begin
            hs_on_out <= 1'b0;
            sense_out <= 16'h0000;
        end
        else if (go_in)
            hs_on_out <= 1'b1;
        else if (hs_on_out)
            sense_out <= sense_out + SLOPE;
    end
endmodule

`default_nettype wire

// ==== sim/tb_top.sv ====
// Self-checking bench for the set-point law
`timescale 1ns/1ps
`default_nettype none
`include "pcs_map.svh"

module tb_top;
    localparam logic [15:0] SLOPE = 16'h0040;
    logic        mclk_in, rst_n_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out;
    logic        cycle_start_in, hs_on_in, burst_active_in, startup_active_in, go, er;
    logic        update_done_out, hs_end_out;
    logic [7:0]  paddr_in;
    logic [31:0] pwdata_in, prdata_out, rd;
    logic [15:0] feedback_pin_in, input_voltage_sense_pin_in, zero_cross_pin_in, sense_code_in;
    logic [15:0] base_half_bridge_period_in, extended_half_bridge_period_in, ls_on_request_in;
    logic [15:0] threshold_out, setpoint_out, delay_compensation_out, ls_on_time_out;
    logic [15:0] positive_magnetization_target_out, negative_magnetization_target_out;
    logic [15:0] wait_gap_out, peak, sp;
    int          fails, num_checks, n, i;

    pcs_setpoint_law pcs_setpoint_law_i (.*);
    pcs_stage_model #(.SLOPE(SLOPE)) pcs_stage_model_i (.mclk_in, .rst_n_in, .go_in(go),
        .hs_end_in(hs_end_out), .hs_on_out(hs_on_in), .sense_out(sense_code_in), .peak_out(peak));

    initial
    begin
        mclk_in = 1'b0;
        forever #25 mclk_in = ~mclk_in;
    end

    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e)
        begin
            $display("mismatch at %0t: got %h want %h", $time, g, e);
            fails++;
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Bounded wait on a settled flag, sampled between edges
    task automatic wait_for(ref logic f, input logic v);
        n = 0;
        do
        begin
            @(negedge mclk_in);
            n++;
        end
        while (f !== v && n < 250);
        chk(16'(n < 250), 16'h0001);
        if (n == 250)
            print_verdict();
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge mclk_in);
        penable_in <= 1'b1;
        wait_for(pready_out, 1'b1);
        rd = prdata_out;
        er = pslverr_out;
        @(posedge mclk_in);
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask

    task automatic calc(input logic [15:0] s, t, p, g, o, w);
        @(posedge mclk_in);
        cycle_start_in <= 1'b1;
        @(posedge mclk_in);
        cycle_start_in <= 1'b0;
        wait_for(update_done_out, 1'b1);
        chk(setpoint_out, s);
        chk(threshold_out, t);
        chk(positive_magnetization_target_out, p);
        chk(negative_magnetization_target_out, g);
        chk(delay_compensation_out, o);
        chk(wait_gap_out, w);
        @(posedge mclk_in);
    endtask

    initial
    begin
        {rst_n_in, psel_in, penable_in, pwrite_in, cycle_start_in, go} = '0;
        {burst_active_in, startup_active_in, paddr_in, pwdata_in} = '0;
        {feedback_pin_in, input_voltage_sense_pin_in, zero_cross_pin_in} = '0;
        {base_half_bridge_period_in, extended_half_bridge_period_in, ls_on_request_in} = '0;
        fails = 0;
        num_checks = 0;
        repeat (8) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        apb(1'b0, `PCS_OFF_SP_MAX, 32'h0000_0000);
        chk(rd[15:0], `PCS_RST_SP_MAX);
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk(16'(er), 16'h0001);
        apb(1'b1, `PCS_OFF_CTRL, 32'h0000_0001);
        feedback_pin_in <= 16'h0500;
        {input_voltage_sense_pin_in, zero_cross_pin_in} <= {16'h0100, 16'h0100};
        ls_on_request_in <= 16'h0010;
        base_half_bridge_period_in <= 16'h0100;
        extended_half_bridge_period_in <= 16'h0200;
        calc(16'h0100, 16'h0230, 16'h01D0, 16'h0030, 16'h0000, 16'h0000); // law
        chk(ls_on_time_out, 16'h0040); // floor
        input_voltage_sense_pin_in <= 16'h0300;
        calc(16'h0100, 16'h0240, 16'h01A0, 16'h0050, 16'h0010, 16'h0000); // pdc
        apb(1'b0, `PCS_OFF_RESULT, 32'h0000_0000);
        chk(rd[31:16], 16'h0010); // overshoot readback
        for (i = 0; i < 4; i++)
        begin
            sp = i == 0 ? 16'h0200 : i == 1 ? 16'h0040 : i == 2 ? 16'h0280 : 16'h0020;
            feedback_pin_in <= i == 0 ? 16'hFFFF : i == 3 ? 16'h0110 : 16'h0500;
            burst_active_in <= i == 1;
            startup_active_in <= i == 2;
            calc(sp, sp > 16'h01E0 ? 16'h0400 : sp + sp + 16'h0040, // clamps
                sp > 16'h0030 ? sp + sp - 16'h0060 : 16'h0000, 16'h0050, 16'h0010, 16'h0000);
        end
        {burst_active_in, startup_active_in} <= 2'b00;
        feedback_pin_in <= 16'h0500;
        input_voltage_sense_pin_in <= 16'h0100;
        apb(1'b1, `PCS_OFF_CTRL, 32'h0000_0003);
        calc(16'h0100, 16'h0400, 16'h01D0, 16'h0030, 16'h0000, 16'h0100); // valley
        @(posedge mclk_in);
        go <= 1'b1;
        @(posedge mclk_in);
        go <= 1'b0;
        wait_for(hs_on_in, 1'b0);
        chk(peak, 16'h0400 + SLOPE); // peak stop
        print_verdict();
    end
endmodule

bind pcs_setpoint_law pcs_law_asserts pcs_law_asserts_i (.*);

`default_nettype wire
